/* core/bpb_pkg.sv */
// Shared constants for the bidirectional port bank.
package bpb_pkg;

    ////////////////////////////////////////////////////////////////////////////
    // File addresses of the port registers.
    localparam int BPB_ADDR_W = 5;
    localparam logic [4:0] BPB_FIRST_ADDR = 5'h05;
    localparam logic [4:0] BPB_SECOND_ADDR = 5'h06;
    localparam logic [4:0] BPB_THIRD_ADDR = 5'h07;

    ////////////////////////////////////////////////////////////////////////////
    // Widths and field positions.
    localparam int BPB_DATA_W = 8;
    localparam int BPB_FIRST_W = 4;
    localparam int BPB_PORT_W = 8;
    localparam int BPB_BIT_SEL_W = 3;
    localparam int BPB_FIRST_MSB = 3;
    localparam int BPB_UPPER_LSB = 4;

    ////////////////////////////////////////////////////////////////////////////
    // Values after reset, fixed read values and the bit mask seed.
    localparam logic [7:0] BPB_DIR_RESET = 8'hff;
    localparam logic [7:0] BPB_READ_ZERO = 8'h00;
    localparam logic [3:0] BPB_UPPER_ZERO = 4'h0;
    localparam logic [7:0] BPB_BIT_ONE = 8'h01;

endpackage

/* core/bpb_bitop.sv */
// Bit set and bit clear of one byte for read-modify-write operations.
`timescale 1ns/1ps
module bpb_bitop
    import bpb_pkg::*;
(
    input logic [BPB_DATA_W-1:0] src,
    input logic [BPB_BIT_SEL_W-1:0] bit_sel,
    input logic bit_set,
    output logic [BPB_DATA_W-1:0] result
);

    logic [BPB_DATA_W-1:0] mask;

    assign mask = BPB_DATA_W'(BPB_BIT_ONE << bit_sel);
    assign result = bit_set ? (src | mask) : (src & ~mask);

endmodule

/* core/bpb_port.sv */
// One port slice: output latches, direction bits and driver enables.
`timescale 1ns/1ps
module bpb_port
    import bpb_pkg::*;
#(
    parameter int WIDTH = BPB_PORT_W
)
(
    input logic clk,
    input logic sys_rst,
    input logic latch_wr,
    input logic [WIDTH-1:0] latch_val,
    input logic dir_wr,
    input logic [WIDTH-1:0] dir_val,
    output logic [WIDTH-1:0] latch_q,
    output logic [WIDTH-1:0] pin_oe
);

    logic [WIDTH-1:0] direction;

    ////////////////////////////////////////////////////////////////////////////
    // The latches take no reset, so a warm reset leaves driven levels intact.
    always_ff @(posedge clk) begin
        if (latch_wr) begin
            latch_q <= latch_val;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            direction <= WIDTH'(BPB_DIR_RESET);
        end else if (dir_wr) begin
            direction <= dir_val;
        end
    end

    // A one turns the driver off; each bit stands alone.
    assign pin_oe = ~direction;

endmodule

/* core/bpb_top.sv */
// Bidirectional port bank with three ports behind the file register space.
`timescale 1ns/1ps

// Behaviour
// - Port reads return pin levels, not latches.
// - Any reset sets all direction bits.
// - First port has four pins; upper bits zero.
// - Second port has eight bidirectional pins.
// - Third port is pins or plain register.
// - Direction loads only from accumulator, write-only.
// - Direction one floats pin; zero drives latch.
// - Latches hold until written again.
// - Each pin direction is set independently.
// - Bit ops write back pins into latches.
// - Writes land at cycle end; reads sample pins at that same edge.
module bpb_top
    import bpb_pkg::*;
#(
    parameter logic THIRD_IS_IO = 1'b1
)
(
    input logic clk,
    input logic sys_rst,
    input logic [BPB_ADDR_W-1:0] reg_addr,
    input logic [BPB_DATA_W-1:0] acc_data,
    input logic wr_en,
    input logic bit_op_en,
    input logic bit_op_set,
    input logic [BPB_BIT_SEL_W-1:0] bit_sel,
    input logic dir_load_en,
    input logic rd_en,
    output logic [BPB_DATA_W-1:0] rd_data,
    output logic rd_hit,
    input logic [BPB_FIRST_W-1:0] first_port_pin_in,
    output logic [BPB_FIRST_W-1:0] first_port_pin_out,
    output logic [BPB_FIRST_W-1:0] first_port_pin_oe,
    input logic [BPB_PORT_W-1:0] second_port_pin_in,
    output logic [BPB_PORT_W-1:0] second_port_pin_out,
    output logic [BPB_PORT_W-1:0] second_port_pin_oe,
    input logic [BPB_PORT_W-1:0] third_port_pin_in,
    output logic [BPB_PORT_W-1:0] third_port_pin_out,
    output logic [BPB_PORT_W-1:0] third_port_pin_oe
);

    logic sel_first;
    logic sel_second;
    logic sel_third;
    logic sel_any;
    logic latch_op;
    logic [BPB_DATA_W-1:0] first_view;
    logic [BPB_DATA_W-1:0] second_view;
    logic [BPB_DATA_W-1:0] third_view;
    logic [BPB_DATA_W-1:0] port_view;
    logic [BPB_DATA_W-1:0] bit_result;
    logic [BPB_DATA_W-1:0] next_latch;
    logic [BPB_FIRST_W-1:0] first_latch;
    logic [BPB_PORT_W-1:0] second_latch;
    logic [BPB_PORT_W-1:0] third_latch;
    logic [BPB_PORT_W-1:0] third_oe_raw;
    logic [BPB_DATA_W-1:0] next_rd_data;

    ////////////////////////////////////////////////////////////////////////////
    // Address decode.
    assign sel_first = (reg_addr == BPB_FIRST_ADDR);
    assign sel_second = (reg_addr == BPB_SECOND_ADDR);
    assign sel_third = (reg_addr == BPB_THIRD_ADDR);
    assign sel_any = sel_first | sel_second | sel_third;

    // Writes are dropped during reset so the latches really keep their value.
    assign latch_op = !sys_rst && (wr_en || bit_op_en);

    ////////////////////////////////////////////////////////////////////////////
    // What the program sees when it reads each location.
    assign first_view = {BPB_UPPER_ZERO, first_port_pin_in};
    assign second_view = second_port_pin_in;
    // As a plain register the third location reads back its own storage.
    assign third_view = THIRD_IS_IO ? third_port_pin_in : third_latch;

    always_comb begin
        port_view = BPB_READ_ZERO;
        if (sel_first) begin
            port_view = first_view;
        end else if (sel_second) begin
            port_view = second_view;
        end else if (sel_third) begin
            port_view = third_view;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Bit operations start from the pins, so input latches pick up pin levels.
    bpb_bitop u_bitop (
        .src(port_view),
        .bit_sel(bit_sel),
        .bit_set(bit_op_set),
        .result(bit_result)
    );

    // A plain write outranks a bit operation issued in the same cycle.
    assign next_latch = wr_en ? acc_data : bit_result;

    ////////////////////////////////////////////////////////////////////////////
    // Port slices.
    bpb_port #(
        .WIDTH(BPB_FIRST_W)
    ) u_first (
        .clk(clk),
        .sys_rst(sys_rst),
        .latch_wr(latch_op && sel_first),
        .latch_val(next_latch[BPB_FIRST_MSB:0]),
        .dir_wr(dir_load_en && sel_first),
        .dir_val(acc_data[BPB_FIRST_MSB:0]),
        .latch_q(first_latch),
        .pin_oe(first_port_pin_oe)
    );

    bpb_port #(
        .WIDTH(BPB_PORT_W)
    ) u_second (
        .clk(clk),
        .sys_rst(sys_rst),
        .latch_wr(latch_op && sel_second),
        .latch_val(next_latch),
        .dir_wr(dir_load_en && sel_second),
        .dir_val(acc_data),
        .latch_q(second_latch),
        .pin_oe(second_port_pin_oe)
    );

    bpb_port #(
        .WIDTH(BPB_PORT_W)
    ) u_third (
        .clk(clk),
        .sys_rst(sys_rst),
        .latch_wr(latch_op && sel_third),
        .latch_val(next_latch),
        .dir_wr(dir_load_en && sel_third && THIRD_IS_IO),
        .dir_val(acc_data),
        .latch_q(third_latch),
        .pin_oe(third_oe_raw)
    );

    assign first_port_pin_out = first_latch;
    assign second_port_pin_out = second_latch;
    // Without pins the third location never drives anything outward.
    assign third_port_pin_out = THIRD_IS_IO ? third_latch : BPB_READ_ZERO;
    assign third_port_pin_oe = THIRD_IS_IO ? third_oe_raw : BPB_READ_ZERO;

    ////////////////////////////////////////////////////////////////////////////
    // Read path: pins are sampled at the edge that closes the read cycle.
    // Nothing holds the level, so a pulse shorter than that is missed.
    assign next_rd_data = port_view;

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            rd_data <= BPB_READ_ZERO;
        end else if (rd_en) begin
            rd_data <= next_rd_data;
        end
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            rd_hit <= 1'b0;
        end else begin
            rd_hit <= rd_en && sel_any;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Checks.
    a_read_second_pins: assert property (
        @(posedge clk) disable iff (sys_rst)
        rd_en && sel_second |=> rd_data == $past(second_port_pin_in) && rd_hit
    ) else $error("second port read did not return pin levels");

    a_read_first_pins: assert property (
        @(posedge clk) disable iff (sys_rst)
        rd_en && sel_first |=>
            rd_data[7:BPB_UPPER_LSB] == BPB_UPPER_ZERO &&
            rd_data[BPB_FIRST_MSB:0] == $past(first_port_pin_in)
    ) else $error("first port read wrong or upper bits not zero");

    a_reset_floats_pins: assert property (
        @(posedge clk)
        sys_rst |=> first_port_pin_oe == BPB_UPPER_ZERO &&
            second_port_pin_oe == BPB_READ_ZERO && third_port_pin_oe == BPB_READ_ZERO
    ) else $error("a pin still drives after reset");

    a_write_second_latch: assert property (
        @(posedge clk) disable iff (sys_rst)
        wr_en && sel_second |=> second_port_pin_out == $past(acc_data)
    ) else $error("second port latch missed a write");

    a_third_variant: assert property (
        @(posedge clk) disable iff (sys_rst)
        !THIRD_IS_IO && rd_en && sel_third |=>
            rd_data == $past(third_latch) && third_port_pin_oe == BPB_READ_ZERO
    ) else $error("third location misbehaves as plain register");

    a_dir_only_by_load: assert property (
        @(posedge clk) disable iff (sys_rst)
        !dir_load_en ##1 !sys_rst |->
            $stable(second_port_pin_oe) && $stable(first_port_pin_oe)
    ) else $error("direction changed without a direction load");

    a_dir_bits_per_pin: assert property (
        @(posedge clk) disable iff (sys_rst)
        dir_load_en && sel_second |=> second_port_pin_oe == ~$past(acc_data)
    ) else $error("driver enables do not follow direction bits");

    a_latch_holds: assert property (
        @(posedge clk) disable iff (sys_rst)
        !(latch_op && sel_second) |=> $stable(second_port_pin_out)
    ) else $error("second port latch changed without a write");

    a_latch_warm_reset: assert property (
        @(posedge clk)
        sys_rst |=> $stable(second_port_pin_out) && $stable(first_port_pin_out)
    ) else $error("latch changed during reset");

    a_bit_set_rmw: assert property (
        @(posedge clk) disable iff (sys_rst)
        bit_op_en && bit_op_set && !wr_en && sel_second |=>
            second_port_pin_out ==
            ($past(second_port_pin_in) | BPB_DATA_W'(BPB_BIT_ONE << $past(bit_sel)))
    ) else $error("bit set did not write back pin levels");

    a_bit_clear_rmw: assert property (
        @(posedge clk) disable iff (sys_rst)
        bit_op_en && !bit_op_set && !wr_en && sel_second |=>
            second_port_pin_out ==
            ($past(second_port_pin_in) & ~BPB_DATA_W'(BPB_BIT_ONE << $past(bit_sel)))
    ) else $error("bit clear did not write back pin levels");

    a_read_before_write: assert property (
        @(posedge clk) disable iff (sys_rst)
        rd_en && wr_en && sel_second |=> rd_data == $past(second_port_pin_in)
    ) else $error("read in a write cycle did not see old pins");

    a_unmapped_read: assert property (
        @(posedge clk) disable iff (sys_rst)
        rd_en && !sel_any |=> rd_data == BPB_READ_ZERO && !rd_hit
    ) else $error("unmapped read not zero");

    a_dir_first_load: assert property (
        @(posedge clk) disable iff (sys_rst)
        dir_load_en && sel_first |=> first_port_pin_oe == ~$past(acc_data[BPB_FIRST_MSB:0])
    ) else $error("first port driver enables do not follow direction bits");

    a_dir_third_load: assert property (
        @(posedge clk) disable iff (sys_rst)
        THIRD_IS_IO && dir_load_en && sel_third |=> third_port_pin_oe == ~$past(acc_data)
    ) else $error("third port driver enables do not follow direction bits");

    a_plain_pins_dead: assert property (
        @(posedge clk) disable iff (sys_rst)
        !THIRD_IS_IO |->
            third_port_pin_oe == BPB_READ_ZERO && third_port_pin_out == BPB_READ_ZERO
    ) else $error("plain register drives its pins");

    a_write_first_latch: assert property (
        @(posedge clk) disable iff (sys_rst)
        wr_en && sel_first |=> first_port_pin_out == $past(acc_data[BPB_FIRST_MSB:0])
    ) else $error("first port latch missed a write");

    a_write_third_latch: assert property (
        @(posedge clk) disable iff (sys_rst)
        wr_en && sel_third |=> third_latch == $past(acc_data)
    ) else $error("third location missed a write");

    a_read_third_pins: assert property (
        @(posedge clk) disable iff (sys_rst)
        THIRD_IS_IO && rd_en && sel_third |=> rd_data == $past(third_port_pin_in)
    ) else $error("third port read did not return pin levels");

    a_hit_needs_read: assert property (
        @(posedge clk) disable iff (sys_rst)
        rd_hit |-> $past(rd_en) && $past(sel_any)
    ) else $error("read hit without a mapped read");

    a_read_data_holds: assert property (
        @(posedge clk) disable iff (sys_rst)
        !rd_en |=> $stable(rd_data)
    ) else $error("read data changed without a read");

    a_first_latch_holds: assert property (
        @(posedge clk) disable iff (sys_rst)
        !(latch_op && sel_first) |=> $stable(first_port_pin_out)
    ) else $error("first port latch changed without a write");

    a_third_latch_holds: assert property (
        @(posedge clk) disable iff (sys_rst)
        !(latch_op && sel_third) |=> $stable(third_latch)
    ) else $error("third location changed without a write");

    a_reset_clears_read: assert property (
        @(posedge clk)
        sys_rst |=> rd_data == BPB_READ_ZERO && !rd_hit
    ) else $error("read outputs not cleared by reset");

endmodule

/* tb/bpb_pin_model.sv */
// Outside circuitry on one port: optional drivers and pull-ups on every pin.
`timescale 1ns/1ps
module bpb_pin_model #(
    parameter int W = 8
)
(
    input wire logic [W-1:0] pin_out,
    input wire logic [W-1:0] pin_oe,
    input wire logic ext_drive,
    input wire logic [W-1:0] ext_val,
    output logic [W-1:0] pin_in
);
    ////////////////////////////////////////////////////////////////////////////
    // A released line floats up, so a stale level can never be read by chance.
    // The outside level is held steady until the bench changes it.
    assign pin_in = (pin_oe & pin_out) | (~pin_oe & (ext_drive ? ext_val : {W{1'b1}}));
endmodule

/* tb/test_bidirectional_port_bank.sv */
// Self-checking bench for the port bank with outside circuitry models.
`timescale 1ns/1ps
module test_bidirectional_port_bank;
    import bpb_pkg::*;
    logic clk = 1'b0;
    logic sys_rst = 1'b1;
    logic [4:0] reg_addr = 5'h00;
    logic [7:0] acc_data = 8'h00;
    logic wr_en = 1'b0;
    logic bit_op_en = 1'b0;
    logic bit_op_set = 1'b0;
    logic [2:0] bit_sel = 3'h0;
    logic dir_load_en = 1'b0;
    logic rd_en = 1'b0;
    logic [7:0] rd_data;
    logic rd_hit;
    logic [7:0] p_rd, p_c_out, p_c_oe;
    logic [3:0] a_in, a_out, a_oe;
    logic [7:0] b_in, b_out, b_oe, c_in, c_out, c_oe;
    logic [2:0] drv = 3'h0;
    logic [7:0] ext_a = 8'h00;
    logic [7:0] ext_b = 8'h00;
    logic [7:0] ext_c = 8'h00;
    int failures = 0;
    int cmp_count = 0;
    int cycles = 0;

    always #4 clk = ~clk;

    bpb_top #(.THIRD_IS_IO(1'b1)) i_dut (.clk(clk), .sys_rst(sys_rst), .reg_addr(reg_addr),
        .acc_data(acc_data), .wr_en(wr_en), .bit_op_en(bit_op_en), .bit_op_set(bit_op_set),
        .bit_sel(bit_sel), .dir_load_en(dir_load_en), .rd_en(rd_en), .rd_data(rd_data),
        .rd_hit(rd_hit), .first_port_pin_in(a_in), .first_port_pin_out(a_out),
        .first_port_pin_oe(a_oe), .second_port_pin_in(b_in), .second_port_pin_out(b_out),
        .second_port_pin_oe(b_oe), .third_port_pin_in(c_in), .third_port_pin_out(c_out),
        .third_port_pin_oe(c_oe));
    // Variant whose third location is a plain register; its pins must stay dead.
    bpb_top #(.THIRD_IS_IO(1'b0)) i_dut_plain (.clk(clk), .sys_rst(sys_rst),
        .reg_addr(reg_addr), .acc_data(acc_data), .wr_en(wr_en), .bit_op_en(bit_op_en),
        .bit_op_set(bit_op_set), .bit_sel(bit_sel), .dir_load_en(dir_load_en),
        .rd_en(rd_en), .rd_data(p_rd), .rd_hit(), .first_port_pin_in(a_in),
        .first_port_pin_out(), .first_port_pin_oe(), .second_port_pin_in(b_in),
        .second_port_pin_out(), .second_port_pin_oe(), .third_port_pin_in(c_in),
        .third_port_pin_out(p_c_out), .third_port_pin_oe(p_c_oe));
    bpb_pin_model #(.W(4)) i_ma (.pin_out(a_out), .pin_oe(a_oe), .ext_drive(drv[0]),
        .ext_val(ext_a[3:0]), .pin_in(a_in));
    bpb_pin_model #(.W(8)) i_mb (.pin_out(b_out), .pin_oe(b_oe), .ext_drive(drv[1]),
        .ext_val(ext_b), .pin_in(b_in));
    bpb_pin_model #(.W(8)) i_mc (.pin_out(c_out), .pin_oe(c_oe), .ext_drive(drv[2]),
        .ext_val(ext_c), .pin_in(c_in));

    ////////////////////////////////////////////////////////////////////////////
    task automatic report_and_stop();
        if (failures == 0 && cmp_count > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask

    task automatic check(input logic [7:0] got, input logic [7:0] exp);
        cmp_count++;
        if (got !== exp) begin
            failures++;
            $display("[FAIL] %0t got %h expected %h", $time, got, exp);
        end
    endtask

    // One instruction: en is {rd, dir, bit op, write}; outputs are settled on return.
    // The enables stay up until the next call replaces them in that same time step.
    task automatic req(input logic [4:0] a, input logic [7:0] d, input logic [3:0] en);
        reg_addr = a;
        acc_data = d;
        {rd_en, dir_load_en, bit_op_en, wr_en} = en;
        @(posedge clk);
        #1;
    endtask

    ////////////////////////////////////////////////////////////////////////////
    task automatic t_reset_read();
        check({4'h0, a_oe}, 8'h00);
        check(b_oe | c_oe, 8'h00);
        drv = 3'h1;
        ext_a = 8'hf9;
        req(BPB_FIRST_ADDR, 8'h00, 4'h8);
        check(rd_data, 8'h09);
        check({7'h00, rd_hit}, 8'h01);
    endtask

    task automatic t_mixed_dir();
        drv = 3'h2;
        ext_b = 8'h3c;
        req(BPB_SECOND_ADDR, 8'h0f, 4'h4);
        check(b_oe, 8'hf0);
        req(BPB_SECOND_ADDR, 8'ha5, 4'h1);
        check(b_out, 8'ha5);
        req(BPB_SECOND_ADDR, 8'h00, 4'h8);
        check(rd_data, 8'hac);
        bit_op_set = 1'b0;
        bit_sel = 3'h7;
        req(BPB_SECOND_ADDR, 8'h00, 4'h2);
        check(b_out, 8'h2c);
        bit_op_set = 1'b1;
        bit_sel = 3'h6;
        req(BPB_SECOND_ADDR, 8'h00, 4'h2);
        check(b_out, 8'h6c);
    endtask

    task automatic t_hold();
        req(BPB_SECOND_ADDR, 8'h00, 4'h4);
        check(b_oe, 8'hff);
        check(b_out, 8'h6c);
        {rd_en, dir_load_en, bit_op_en, wr_en} = 4'h0;
        sys_rst = 1'b1;
        @(posedge clk);
        #1;
        sys_rst = 1'b0;
        check(b_oe, 8'h00);
        check(b_out, 8'h6c);
    endtask

    task automatic t_same_cycle();
        drv = 3'h4;
        ext_c = 8'h5a;
        req(BPB_THIRD_ADDR, 8'h3c, 4'h1);
        req(BPB_THIRD_ADDR, 8'h81, 4'h9);
        check(rd_data, 8'h5a);
        check(c_out, 8'h81);
        check(p_rd, 8'h3c);
        check(p_c_out | p_c_oe, 8'h00);
        req(BPB_THIRD_ADDR, 8'h00, 4'h4);
        check(c_oe, 8'hff);
        check(p_c_oe, 8'h00);
        // An unrelated instruction lets the driven pins settle before the read.
        req(5'h10, 8'h00, 4'h0);
        req(BPB_THIRD_ADDR, 8'h00, 4'h8);
        check(rd_data, 8'h81);
        check(p_rd, 8'h81);
        req(BPB_FIRST_ADDR, 8'hf6, 4'h1);
        check({4'h0, a_out}, 8'h06);
        req(BPB_FIRST_ADDR, 8'hfa, 4'h4);
        check({4'h0, a_oe}, 8'h05);
        req(5'h08, 8'h00, 4'h8);
        check({rd_hit, rd_data[6:0]}, 8'h00);
    endtask

    ////////////////////////////////////////////////////////////////////////////
    always @(posedge clk) begin
        cycles++;
        if (cycles == 2000) begin
            failures++;
            report_and_stop();
        end
    end

    initial begin
        repeat (10) @(posedge clk);
        #1;
        sys_rst = 1'b0;
        t_reset_read();
        t_mixed_dir();
        t_hold();
        t_same_cycle();
        report_and_stop();
    end
endmodule
